// ### ttcc_pkg.sv
package ttcc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int CHAN_N    = 4;
    localparam int ADDR_W    = 8;
    localparam int IDX_W     = 6;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] CH0_STATUS_IDX  = 6'h13;
    localparam logic [IDX_W-1:0] CH_STRIDE       = 6'h03;
    localparam logic [IDX_W-1:0] CH_SPAN         = 6'h0C;
    localparam logic [IDX_W-1:0] CH1_VAL_LO_IDX  = 6'h18;
    localparam logic [IDX_W-1:0] CH2_VAL_HI_IDX  = 6'h1A;
    localparam logic [IDX_W-1:0] CH2_VAL_LO_IDX  = 6'h1B;
    localparam logic [IDX_W-1:0] CH3_VAL_HI_IDX  = 6'h1D;
    localparam logic [IDX_W-1:0] CH3_VAL_LO_IDX  = 6'h1E;

    // Register kind within one channel group
    localparam logic [1:0] KIND_STATUS = 2'h0;
    localparam logic [1:0] KIND_VAL_HI = 2'h1;
    localparam logic [1:0] KIND_VAL_LO = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Status and control field positions
    localparam int FLAG_BIT     = 7;
    localparam int IRQ_EN_BIT   = 6;
    localparam int MS_BUF_BIT   = 5;
    localparam int MS_UNBUF_BIT = 4;
    localparam int ELS_HI_BIT   = 3;
    localparam int ELS_LO_BIT   = 2;
    localparam int TOV_BIT      = 1;
    localparam int MAX_BIT      = 0;

    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] VALUE_RST = 16'h0000;

    // Edge/level select codes
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_RISE_TOG = 2'h1;
    localparam logic [1:0] ELS_FALL_CLR = 2'h2;
    localparam logic [1:0] ELS_BOTH_SET = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_PRESET,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_BUFFERED
    } ttcc_mode_e;

    typedef struct packed {
        logic        flag;
        logic        armed;
        logic        irq_en;
        logic        ms_buf;
        logic        ms_unbuf;
        logic [1:0]  els;
        logic        tov;
        logic        max;
        logic        max_act;
        logic        out;
        logic        cap_lock;
        logic        cmp_lock;
        logic [15:0] val;
    } ttcc_chan_s;

    typedef struct packed {
        ttcc_chan_s [CHAN_N-1:0] ch;
        logic [1:0]              pair_sel;
        logic [1:0]              pair_pend;
        logic [1:0]              pair_tgt;
        logic [CHAN_N-1:0]       sync1;
        logic [CHAN_N-1:0]       sync2;
        logic [CHAN_N-1:0]       sync3;
        logic                    aw_have;
        logic [IDX_W-1:0]        aw_idx;
        logic                    w_have;
        logic [7:0]              w_byte;
        logic                    w_lane;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [7:0]              rbyte;
    } ttcc_state_s;

    typedef struct packed {
        logic [15:0] value;
        logic        wrap;
        logic        halt;
        logic        clear;
    } ttcc_counter_s;

endpackage : ttcc_pkg

// ### ttcc_top.sv
`timescale 1ns/1ps
// Operation
// - Capture channel sets its flag on the selected pin edge.
// - Compare channel sets its flag when counter equals value register.
// - Flag clears by status read then zero write, unless new event.
// - Writing one to a flag does nothing; reset clears flag.
// - Per-channel interrupt enable, cleared at reset, gates the request.
// - Buffered select exists only on channels 0 and 2.
// - Buffered pair disables odd channel status and frees its pin.
// - Nonzero edge select: unbuffered bit picks compare or capture.
// - Edge select zero: unbuffered bit sets initial level, one low.
// - Edge select zero leaves pin to port; channel holds preset.
// - Capture edge: 01 rising, 10 falling, 11 both.
// - Compare action: 01 toggle, 10 clear, 11 set.
// - Toggle-on-wrap toggles compare pin at overflow; none in capture.
// - Overflow toggle wins over compare in the same cycle.
// - With toggle-on-wrap and clear action, full-duty force holds output high from the next period.
// - Each channel has a 16-bit read/write capture/compare value.
// - Capture mode: high byte read blocks captures until low read.
// - Compare modes: high byte write blocks matches until low write.
// - Overflow is the counter wrap strobe from the shared counter.
// - Counter halt suppresses captures while set.
module ttcc_top
    import ttcc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // Shared counter
    input  wire logic [15:0]       counter_value,
    input  wire logic              counter_wrap,
    input  wire logic              counter_halt,
    input  wire logic              counter_clear,
    // Channel pins
    input  wire logic [CHAN_N-1:0] channel_pin_in,
    output logic      [CHAN_N-1:0] channel_pin_out,
    output logic      [CHAN_N-1:0] channel_pin_oe,
    output logic      [CHAN_N-1:0] channel_pin_owned,
    // Interrupt requests
    output logic      [CHAN_N-1:0] chan_irq,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode: channel groups of status, high and low
    function automatic logic [4:0] ttcc_decode(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] off;
        logic [1:0]       chan;
        logic [1:0]       kind;
        off  = idx - CH0_STATUS_IDX;
        chan = 2'(off / CH_STRIDE);
        kind = 2'(off % CH_STRIDE);
        ttcc_decode = {(idx >= CH0_STATUS_IDX) && (off < CH_SPAN),
                       chan, kind};
    endfunction : ttcc_decode

    ////////////////////////////////////////////////////////////////////////
    ttcc_state_s   st_reg;
    ttcc_state_s   st_next;
    ttcc_counter_s cnt;
    ttcc_mode_e    mode [CHAN_N];

    logic [4:0]  wr_dec;
    logic [4:0]  rd_dec;
    logic        wr_exec;
    logic        rd_exec;
    logic [7:0]  rd_byte;

    assign cnt = '{value: counter_value, wrap: counter_wrap,
                   halt: counter_halt, clear: counter_clear};

    assign wr_dec  = ttcc_decode(st_reg.aw_idx);
    assign rd_dec  = ttcc_decode(s_axi_araddr[ADDR_W-1:2]);
    assign wr_exec = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign rd_exec = s_axi_arvalid && !st_reg.rvalid;

    assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = {24'h000000, st_reg.rbyte};

    ////////////////////////////////////////////////////////////////////////
    // Mode of each channel from its control bits
    always_comb begin
        for (int i = 0; i < CHAN_N; i++) begin
            ttcc_chan_s c;
            c = st_reg.ch[i];
            if ((i % 2 == 1) && st_reg.ch[i - (i % 2)].ms_buf) begin
                mode[i] = MODE_OFF;
            end else if (c.els == ELS_OFF) begin
                mode[i] = MODE_PRESET;
            end else if ((i % 2 == 0) && c.ms_buf) begin
                mode[i] = MODE_BUFFERED;
            end else if (c.ms_unbuf) begin
                mode[i] = MODE_COMPARE;
            end else begin
                mode[i] = MODE_CAPTURE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data for the accepted read address
    always_comb begin
        ttcc_chan_s c;
        c = st_reg.ch[rd_dec[3:2]];
        rd_byte = 8'h00;
        case (rd_dec[1:0])
            KIND_STATUS: begin
                if (mode[rd_dec[3:2]] != MODE_OFF) begin
                    rd_byte = {c.flag, c.irq_en, c.ms_buf, c.ms_unbuf,
                               c.els, c.tov, c.max};
                end
            end
            KIND_VAL_HI: rd_byte = c.val[15:8];
            KIND_VAL_LO: rd_byte = c.val[7:0];
            default:     rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic             rise;
        logic             fall;
        logic             edge_hit;
        logic             match;
        logic             ev;
        logic             clr;
        logic             wr_here;
        logic             rd_here;
        logic [15:0]      cmp_val;
        logic             cmp_blk;
        logic [7:0]       wb;
        ttcc_chan_s       c;
        rise     = 1'b0;
        fall     = 1'b0;
        edge_hit = 1'b0;
        match    = 1'b0;
        ev       = 1'b0;
        clr      = 1'b0;
        wr_here  = 1'b0;
        rd_here  = 1'b0;
        cmp_val  = VALUE_RST;
        cmp_blk  = 1'b0;
        wb       = st_reg.w_byte;
        c        = st_reg.ch[0];
        st_next  = st_reg;

        // Pins pass two flops before any logic looks at them
        st_next.sync1 = channel_pin_in;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;

        // Bus channels
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_idx  = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_have = 1'b1;
            st_next.w_byte = s_axi_wdata[7:0];
            st_next.w_lane = s_axi_wstrb[0];
        end
        if (wr_exec) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_dec[4] ? RESP_OKAY : RESP_SLVERR;
        end else if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (rd_exec) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = rd_dec[4] ? RESP_OKAY : RESP_SLVERR;
            st_next.rbyte  = rd_dec[4] ? rd_byte : 8'h00;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        for (int i = 0; i < CHAN_N; i++) begin
            c       = st_reg.ch[i];
            ev      = 1'b0;
            clr     = 1'b0;
            wr_here = wr_exec && wr_dec[4] && st_reg.w_lane
                      && (wr_dec[3:2] == 2'(i));
            rd_here = rd_exec && rd_dec[4] && (rd_dec[3:2] == 2'(i));

            // Register writes
            if (wr_here) begin
                case (wr_dec[1:0])
                    KIND_STATUS: begin
                        if (mode[i] != MODE_OFF) begin
                            c.irq_en   = wb[IRQ_EN_BIT];
                            c.ms_unbuf = wb[MS_UNBUF_BIT];
                            c.els      = wb[ELS_HI_BIT:ELS_LO_BIT];
                            c.tov      = wb[TOV_BIT];
                            c.max      = wb[MAX_BIT];
                            if (i % 2 == 0) begin
                                c.ms_buf = wb[MS_BUF_BIT];
                            end
                            // Ones are ignored; zero clears only if armed
                            clr     = !wb[FLAG_BIT] && c.armed;
                            c.armed = 1'b0;
                        end
                    end
                    KIND_VAL_HI: begin
                        c.val[15:8] = wb;
                        if (mode[i] != MODE_CAPTURE) begin
                            c.cmp_lock = 1'b1;
                        end
                    end
                    KIND_VAL_LO: begin
                        c.val[7:0] = wb;
                        c.cmp_lock = 1'b0;
                        // New buffered value takes over at next wrap
                        if (st_reg.ch[i - (i % 2)].ms_buf) begin
                            st_next.pair_pend[i/2] = 1'b1;
                            st_next.pair_tgt[i/2]  = 1'(i % 2);
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // Read side effects
            if (rd_here) begin
                case (rd_dec[1:0])
                    KIND_STATUS: begin
                        if (c.flag && mode[i] != MODE_OFF) begin
                            c.armed = 1'b1;
                        end
                    end
                    KIND_VAL_HI: begin
                        if (mode[i] == MODE_CAPTURE) begin
                            c.cap_lock = 1'b1;
                        end
                    end
                    KIND_VAL_LO: c.cap_lock = 1'b0;
                    default: begin
                    end
                endcase
            end

            // Edge detection on synchronised pin
            rise = st_reg.sync2[i] && !st_reg.sync3[i];
            fall = !st_reg.sync2[i] && st_reg.sync3[i];
            case (st_reg.ch[i].els)
                ELS_RISE_TOG: edge_hit = rise;
                ELS_FALL_CLR: edge_hit = fall;
                ELS_BOTH_SET: edge_hit = rise || fall;
                default:      edge_hit = 1'b0;
            endcase

            // Compare source: buffered pairs alternate between two values
            if (mode[i] == MODE_BUFFERED && st_reg.pair_sel[i/2]) begin
                cmp_val = st_reg.ch[i | 1].val;
                cmp_blk = st_reg.ch[i | 1].cmp_lock;
            end else begin
                cmp_val = st_reg.ch[i].val;
                cmp_blk = st_reg.ch[i].cmp_lock;
            end
            // Counter being cleared gives no match
            match = (cnt.value == cmp_val) && !cmp_blk && !cnt.clear;

            case (mode[i])
                MODE_CAPTURE: begin
                    // Halt and the read lock both hold off captures
                    if (edge_hit && !cnt.halt && !st_reg.ch[i].cap_lock)
                    begin
                        c.val = cnt.value;
                        ev    = 1'b1;
                    end
                end
                MODE_COMPARE, MODE_BUFFERED: begin
                    ev = match;
                    if (cnt.wrap) begin
                        c.max_act = st_reg.ch[i].max;
                    end
                    if (cnt.wrap && st_reg.ch[i].tov) begin
                        c.out = !st_reg.ch[i].out;
                    end else if (match) begin
                        case (st_reg.ch[i].els)
                            ELS_RISE_TOG: c.out = !st_reg.ch[i].out;
                            ELS_FALL_CLR: c.out = 1'b0;
                            ELS_BOTH_SET: c.out = 1'b1;
                            default:      c.out = st_reg.ch[i].out;
                        endcase
                    end
                    if (st_reg.ch[i].tov && st_reg.ch[i].els == ELS_FALL_CLR
                        && c.max_act) begin
                        c.out = 1'b1;
                    end
                    if (mode[i] == MODE_BUFFERED && cnt.wrap
                        && st_reg.pair_pend[i/2]) begin
                        st_next.pair_sel[i/2]  = st_reg.pair_tgt[i/2];
                        st_next.pair_pend[i/2] = 1'b0;
                    end
                end
                MODE_PRESET: begin
                    c.out     = !st_reg.ch[i].ms_unbuf;
                    c.max_act = st_reg.ch[i].max;
                end
                default: begin
                end
            endcase

            // A new event beats a clear in the same cycle
            if (ev) begin
                c.flag  = 1'b1;
                c.armed = 1'b0;
            end else if (clr) begin
                c.flag = 1'b0;
            end
            st_next.ch[i] = c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin and interrupt outputs
    always_comb begin
        for (int i = 0; i < CHAN_N; i++) begin
            channel_pin_out[i]   = st_reg.ch[i].out;
            // Capture leaves the pin an input; preset leaves it to port
            channel_pin_oe[i]    = (mode[i] == MODE_COMPARE)
                                   || (mode[i] == MODE_BUFFERED);
            channel_pin_owned[i] = (mode[i] != MODE_OFF)
                                   && (mode[i] != MODE_PRESET);
            chan_irq[i] = st_reg.ch[i].flag && st_reg.ch[i].irq_en
                          && (mode[i] != MODE_OFF);
        end
    end

endmodule : ttcc_top

// ### ttcc_top_sva.sv
`timescale 1ns/1ps
module ttcc_top_sva
    import ttcc_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // Bus handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata,
    // Channel outputs
    input wire logic [CHAN_N-1:0] channel_pin_oe,
    input wire logic [CHAN_N-1:0] channel_pin_owned,
    input wire logic [CHAN_N-1:0] chan_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (
        $rose(resetn) |-> chan_irq == 4'h0 && channel_pin_oe == 4'h0)
        else $error("irq or pin drive on after reset");
    a_drive_owned: assert property (
        (channel_pin_oe & ~channel_pin_owned) == 4'h0)
        else $error("pin driven while not owned");
    // Mode bits only move by register writes
    a_owned_write: assert property (
        $changed(channel_pin_owned) |-> $rose(s_axi_bvalid))
        else $error("pin ownership changed without a write");
    a_oe_write: assert property (
        $changed(channel_pin_oe) |-> $rose(s_axi_bvalid))
        else $error("pin drive changed without a write");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read data late or wide");
    a_resp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_data_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule : ttcc_top_sva
bind ttcc_top ttcc_top_sva u_ttcc_top_sva (.*);

// ### ttcc_counter_model.sv
`timescale 1ns/1ps
module ttcc_counter_model #(
    parameter logic [15:0] MODULO = 16'h0013
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Control
    input  wire logic        halt,
    input  wire logic        clear,
    // Counter
    output logic [15:0]      value,
    output logic             wrap
);
    // Strobe comes with the restart, so compare at zero sees it
    always_ff @(posedge clk) begin
        if (!resetn || clear) begin
            value <= 16'h0000;
            wrap  <= 1'b0;
        end else begin
            wrap <= !halt && value == MODULO;
            if (!halt) begin
                value <= (value == MODULO) ? 16'h0000 : value + 16'h0001;
            end
        end
    end
endmodule : ttcc_counter_model

// ### tb_ttcc_top.sv
`timescale 1ns/1ps
module tb_ttcc_top
    import ttcc_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, halt = 1'b1, clr = 1'b1;
    logic [3:0]  pin = 4'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, b;
    logic [31:0] wdata = 32'h00000000;
    logic [1:0]  rsp;
    logic        awready, wready, bvalid, arready, rvalid, wrap;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [3:0]  pout, poe, pown, irq;
    int          mismatches = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    ttcc_counter_model u_ttcc_counter_model (.clk(clk), .resetn(resetn),
        .halt(halt), .clear(clr), .value(cnt), .wrap(wrap));
    ttcc_top u_ttcc_top (.clk(clk), .resetn(resetn), .ce(1'b1),
        .counter_value(cnt), .counter_wrap(wrap), .counter_halt(halt),
        .counter_clear(clr), .channel_pin_in(pin), .channel_pin_out(pout),
        .channel_pin_oe(poe), .channel_pin_owned(pown), .chan_irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [5:0] st(input int n);
        return CH0_STATUS_IDX + CH_STRIDE * 6'(n);
    endfunction : st
    // Readiness is read at the falling edge: same value the rising edge takes
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic pa, pw, pb, ta, tw, tb;
        @(posedge clk);
        {pa, pw, pb} = 3'h7;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h000000, v};
        {awvalid, wvalid, bready} <= 3'h7;
        while (pb) begin
            @(negedge clk);
            {ta, tw, tb} = {pa & awready, pw & wready, bvalid};
            if (tb) rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            {pa, pw, pb} = {pa & !ta, pw & !tw, !tb};
        end
    endtask : wr
    task automatic rd(input logic [5:0] idx);
        logic pa, pr, ta, tr;
        @(posedge clk);
        {pa, pr} = 2'h3;
        araddr <= {idx, 2'h0};
        {arvalid, rready} <= 2'h3;
        while (pr) begin
            @(negedge clk);
            {ta, tr} = {pa & arready, rvalid};
            if (tr) {d, rsp} = {rdata[7:0], rresp};
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            {pa, pr} = {pa & !ta, !tr};
        end
    endtask : rd
    task automatic ctr(input logic h, input logic c);
        @(posedge clk);
        halt <= h;
        clr <= c;
    endtask : ctr
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wwrap();
        while (wrap !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : wwrap
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({pout, poe, pown, irq}, 16'hF000);
        rd(st(0));
        chk({6'h00, rsp, d}, 16'h0000);
        rd(6'h3F);
        chk({6'h00, rsp, d}, {6'h00, RESP_SLVERR, 8'h00});
        wr(st(0), 8'h10);
        settle(1);
        chk({13'h0000, rsp, pout[0]}, {13'h0000, RESP_OKAY, 1'b0});
    endtask : t_reset
    task automatic t_capture();
        // Pins held low since time zero before capture is enabled
        for (int k = 1; k < 4; k++) wr(st(k), 8'h40 | 8'(k << 2));
        pin <= 4'hE;
        settle(8);
        chk({12'h000, irq}, 16'h0000);
        ctr(1'b0, 1'b0);
        pin <= 4'h0;
        settle(8);
        chk({12'h000, irq}, 16'h000C);
        @(posedge clk);
        pin <= 4'hE;
        settle(8);
        chk({12'h000, irq}, 16'h000E);
        rd(st(1));
        chk({8'h00, d}, 16'h00C4);
        wr(st(1), 8'h44);
        wr(st(2), 8'h88);
        settle(1);
        chk({12'h000, irq}, 16'h0008);
        rd(st(2));
        chk({8'h00, d}, 16'h0088);
    endtask : t_capture
    task automatic t_compare();
        wr(st(0) + 6'h01, 8'h00);
        wr(st(0) + 6'h02, 8'h05);
        rd(st(0) + 6'h02);
        chk({8'h00, d}, 16'h0005);
        for (int e = 1; e < 4; e++) begin
            ctr(1'b1, 1'b1);
            rd(st(0));
            wr(st(0), 8'h50 | 8'(e << 2));
            settle(1);
            chk({15'h0000, irq[0]}, 16'h0000);
            b = pout[0];
            ctr(1'b0, 1'b0);
            while (irq[0] !== 1'b1) @(negedge clk);
            chk({15'h0000, pout[0]}, {15'h0000, (e == 1) ? ~b : e == 3});
            chk({14'h0000, poe[0], pown[0]}, 16'h0003);
        end
    endtask : t_compare
    task automatic t_wrap();
        ctr(1'b1, 1'b1);
        wr(st(0), 8'h1A);
        ctr(1'b0, 1'b0);
        wwrap();
        chk({15'h0000, pout[0]}, 16'h0001);
        settle(8);
        chk({15'h0000, pout[0]}, 16'h0000);
        wr(st(0), 8'h1B);
        wwrap();
        wwrap();
        settle(8);
        chk({15'h0000, pout[0]}, 16'h0001);
        wr(st(0), 8'h18);
        wwrap();
        settle(8);
        chk({15'h0000, pout[0]}, 16'h0000);
    endtask : t_wrap
    task automatic t_pair();
        ctr(1'b1, 1'b1);
        wr(st(0), 8'h24);
        rd(st(1));
        chk({7'h00, pown[1], d}, 16'h0000);
        rd(st(0));
        chk({8'h00, d & 8'h7F}, 16'h0024);
        wr(st(3), 8'h20);
        rd(st(3));
        chk({8'h00, d}, 16'h0080);
    endtask : t_pair
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        settle(2);
        t_reset();
        t_capture();
        t_compare();
        t_wrap();
        t_pair();
        stop_test();
    end
endmodule : tb_ttcc_top
